// [rtc_defs.svh]
// constants for the recording trigger controller: offsets, fields, resets, timing
// assumes inclusion by its bare name from the package; the controller uses its macros
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RTC_OFF_CTRL    12'h000
`define RTC_OFF_CMD     12'h004
`define RTC_OFF_LEVEL   12'h008
`define RTC_OFF_SPAN    12'h00c
`define RTC_OFF_AREA    12'h010
`define RTC_OFF_RANGE1  12'h014
`define RTC_OFF_POST    12'h018
`define RTC_OFF_PRE     12'h01c
`define RTC_OFF_STATUS  12'h020

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RTC_CTRL_SRC_LSB  0
`define RTC_CTRL_COND_LSB 2
`define RTC_CMD_DIRECT    0
`define RTC_CMD_BUFFERED  1
`define RTC_CMD_STOP      2

// ----------------------------------------------------------------------------
// value scale: one sample lsb is 10 mV, so 200 V is 20000 counts
// ----------------------------------------------------------------------------
`define RTC_LEVEL_MAX   16'sh4e20
`define RTC_LEVEL_MIN   16'shb1e0
`define RTC_SPAN_MAX    16'h4e20

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RTC_RST_CTRL    4'h0
`define RTC_RST_LEVEL   16'h0000
`define RTC_RST_SPAN    16'h0000
`define RTC_RST_AREA_HI 16'h4e20
`define RTC_RST_AREA_LO 16'hb1e0
`define RTC_RST_RANGE1  16'h2710
`define RTC_RST_POST    32'h0000_0000
`define RTC_RST_PRE     32'h0000_0000

// ----------------------------------------------------------------------------
// timing: clock rate and blink half period
// ----------------------------------------------------------------------------
`define RTC_CLK_KHZ     40000
`define RTC_BLINK_MS    250

`endif

// [rtc_pkg.sv]
// types shared by the recording trigger controller
// assumes rtc_defs.svh is on the include path
package rtc_pkg;
  `include "rtc_defs.svh"

  // --------------------------------------------------------------------------
  // controller states, gray along idle-search-delay-record
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RTC_IDLE   = 2'h0,
    RTC_SEARCH = 2'h1,
    RTC_DELAY  = 2'h3,
    RTC_RECORD = 2'h2
  } rtc_state_t;

  // trigger sources
  typedef enum logic [1:0] {
    RTC_SRC_MANUAL   = 2'h0,
    RTC_SRC_EXTERNAL = 2'h1,
    RTC_SRC_INTERNAL = 2'h2
  } rtc_src_t;

  // internal conditions
  typedef enum logic [1:0] {
    RTC_COND_ABOVE   = 2'h0,
    RTC_COND_BELOW   = 2'h1,
    RTC_COND_OUTSIDE = 2'h2,
    RTC_COND_INSIDE  = 2'h3
  } rtc_cond_t;

  // trigger selection carried together
  typedef struct packed {
    rtc_cond_t cond;
    rtc_src_t  src;
  } rtc_cfg_t;

  // one-cycle front-panel commands
  typedef struct packed {
    logic stop;
    logic buffered;
    logic direct;
  } rtc_cmd_t;
endpackage

// [rtc_trigger_ctrl.sv]
// recording trigger controller: source select, level/window compare, delay, led
// assumes apb master on pclk, channel 1 samples from logic on pclk,
// remote trigger line from a pin whose pull-up the controller enables through remote_event_pullup_en
`timescale 1ns/1ps
module rtc_trigger_ctrl #(
  parameter int unsigned BLINK_HALF_CYC = `RTC_BLINK_MS * `RTC_CLK_KHZ
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic signed [15:0] ch1_sample,
  input  wire logic              ch1_valid,
  input  wire logic              rec_done,
  input  wire logic              remote_event_pin_in,
  output logic                   remote_event_pin_out,
  output logic                   remote_event_pin_oe,
  output logic                   remote_event_pullup_en,
  output logic                   trigger_pulse,
  output logic                   recording,
  output logic                   buffered_mode,
  output logic                   pretrig_store,
  output logic                   search_led,
  output logic                   level_flag,
  output logic                   span_flag
);
  import rtc_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  rtc_state_t        state_reg, state_next;     // controller state
  rtc_cfg_t          cfg_reg, cfg_next;         // source and condition
  logic signed [15:0] level_reg, level_next;    // displayed threshold
  logic [15:0]       span_reg, span_next;       // displayed window span
  logic signed [15:0] area_hi_reg, area_hi_next; // recording area top
  logic signed [15:0] area_lo_reg, area_lo_next; // recording area bottom
  logic [15:0]       range1_reg, range1_next;   // channel 1 range
  logic [31:0]       post_reg, post_next;       // post delay, cycles
  logic [31:0]       pre_reg, pre_next;         // pretrigger time, cycles
  logic signed [17:0] eff_lvl_reg, eff_lvl_next; // clamped threshold
  logic [16:0]       eff_half_reg, eff_half_next; // clamped half span
  logic              buf_reg, buf_next;         // buffered recording
  logic              pre_on_reg, pre_on_next;   // pretrigger store permission
  logic [31:0]       dly_reg, dly_next;         // post delay count
  logic [31:0]       blink_reg, blink_next;     // blink divider
  logic              led_reg, led_next;         // led level
  logic              trig_reg, trig_next;       // trigger pulse
  logic [31:0]       rdata_reg, rdata_next;     // read data
  logic              err_reg, err_next;         // unmapped flag
  logic              sync1_reg, sync2_reg, prev_reg; // remote line sampling

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  logic     acc, wr, mapped;
  rtc_cmd_t cmd;
  logic     rec_cmd;
  assign acc = psel & penable;
  assign wr  = acc & pwrite;
  // commands fire in the access cycle, which is the single taking edge
  assign cmd.direct   = wr & (paddr == `RTC_OFF_CMD) & pwdata[`RTC_CMD_DIRECT];
  assign cmd.buffered = wr & (paddr == `RTC_OFF_CMD) & pwdata[`RTC_CMD_BUFFERED];
  assign cmd.stop     = wr & (paddr == `RTC_OFF_CMD) & pwdata[`RTC_CMD_STOP];
  assign rec_cmd      = cmd.direct | cmd.buffered;
  // zero wait states: read data was captured in setup
  assign pready  = 1'b1;
  assign pslverr = err_reg & acc;
  assign prdata  = rdata_reg;

  always_comb begin
    case (paddr)
      `RTC_OFF_CTRL, `RTC_OFF_CMD, `RTC_OFF_LEVEL, `RTC_OFF_SPAN,
      `RTC_OFF_AREA, `RTC_OFF_RANGE1, `RTC_OFF_POST, `RTC_OFF_PRE,
      `RTC_OFF_STATUS: mapped = 1'b1;
      default:         mapped = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // remote line: two flip-flops, then edge detect on the second
  // --------------------------------------------------------------------------
  // sync before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else begin
      sync1_reg <= remote_event_pin_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end
  assign remote_event_pin_out   = 1'b0;
  assign remote_event_pin_oe    = 1'b0;
  assign remote_event_pullup_en = 1'b1;

  logic fall;
  assign fall = prev_reg & ~sync2_reg;

  // --------------------------------------------------------------------------
  // flags and window limits
  // --------------------------------------------------------------------------
  logic [16:0]       twice_range;
  logic signed [17:0] win_hi, win_lo, samp_x;
  assign level_flag  = (level_reg > area_hi_reg) | (level_reg < area_lo_reg);
  assign twice_range = {range1_reg, 1'b0};
  assign span_flag   = {1'b0, span_reg} > twice_range;
  assign win_hi = eff_lvl_reg + $signed({1'b0, eff_half_reg});
  assign win_lo = eff_lvl_reg - $signed({1'b0, eff_half_reg});
  assign samp_x = {{2{ch1_sample[15]}}, ch1_sample};

  // internal condition hit on this sample; channel 1 only
  logic hit;
  always_comb begin
    hit = 1'b0;
    if (ch1_valid) begin
      case (cfg_reg.cond)
        RTC_COND_ABOVE:   hit = samp_x >= eff_lvl_reg;
        RTC_COND_BELOW:   hit = samp_x <= eff_lvl_reg;
        RTC_COND_OUTSIDE: hit = (samp_x >= win_hi) | (samp_x <= win_lo);
        RTC_COND_INSIDE:  hit = (samp_x <= win_hi) & (samp_x >= win_lo);
        default:          hit = 1'b0;
      endcase
    end
  end

  // trigger found during search
  logic found;
  always_comb begin
    case (cfg_reg.src)
      RTC_SRC_EXTERNAL: found = (state_reg == RTC_SEARCH) & fall;
      RTC_SRC_INTERNAL: found = (state_reg == RTC_SEARCH) & hit;
      default:          found = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // register file next values
  // --------------------------------------------------------------------------
  always_comb begin
    cfg_next     = cfg_reg;
    level_next   = level_reg;
    span_next    = span_reg;
    area_hi_next = area_hi_reg;
    area_lo_next = area_lo_reg;
    range1_next  = range1_reg;
    post_next    = post_reg;
    pre_next     = pre_reg;
    rdata_next   = rdata_reg;
    err_next     = err_reg;
    if (wr) begin
      case (paddr)
        `RTC_OFF_CTRL: begin
          cfg_next.src  = (pwdata[1:0] == 2'h3) ? RTC_SRC_INTERNAL : rtc_src_t'(pwdata[1:0]);
          cfg_next.cond = rtc_cond_t'(pwdata[3:2]);
        end
        `RTC_OFF_LEVEL: begin
          if ($signed(pwdata[15:0]) > `RTC_LEVEL_MAX)      level_next = `RTC_LEVEL_MAX;
          else if ($signed(pwdata[15:0]) < `RTC_LEVEL_MIN) level_next = `RTC_LEVEL_MIN;
          else                                            level_next = pwdata[15:0];
        end
        `RTC_OFF_SPAN: span_next = (pwdata[15:0] > `RTC_SPAN_MAX) ? `RTC_SPAN_MAX
                                                                   : pwdata[15:0];
        `RTC_OFF_AREA: begin
          area_hi_next = pwdata[15:0];
          area_lo_next = pwdata[31:16];
        end
        `RTC_OFF_RANGE1: range1_next = pwdata[15:0];
        `RTC_OFF_POST:   post_next   = pwdata;
        `RTC_OFF_PRE:    pre_next    = pwdata;
        default:         ;
      endcase
    end
    // setup cycle captures read data and the error answer
    if (psel & ~penable) begin
      err_next = ~mapped;
      case (paddr)
        `RTC_OFF_CTRL:   rdata_next = {28'h0, cfg_reg.cond, cfg_reg.src};
        `RTC_OFF_LEVEL:  rdata_next = {16'h0, level_reg};
        `RTC_OFF_SPAN:   rdata_next = {16'h0, span_reg};
        `RTC_OFF_AREA:   rdata_next = {area_lo_reg, area_hi_reg};
        `RTC_OFF_RANGE1: rdata_next = {16'h0, range1_reg};
        `RTC_OFF_POST:   rdata_next = post_reg;
        `RTC_OFF_PRE:    rdata_next = pre_reg;
        `RTC_OFF_STATUS: rdata_next = {22'h0, span_flag, level_flag, search_led,
                                       pretrig_store, buf_reg, trig_reg, 2'h0,
                                       state_reg};
        default:         rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg     <= rtc_cfg_t'(`RTC_RST_CTRL);
      level_reg   <= `RTC_RST_LEVEL;
      span_reg    <= `RTC_RST_SPAN;
      area_hi_reg <= `RTC_RST_AREA_HI;
      area_lo_reg <= `RTC_RST_AREA_LO;
      range1_reg  <= `RTC_RST_RANGE1;
      post_reg    <= `RTC_RST_POST;
      pre_reg     <= `RTC_RST_PRE;
      rdata_reg   <= 32'h0;
      err_reg     <= 1'b0;
    end else begin
      cfg_reg     <= cfg_next;
      level_reg   <= level_next;
      span_reg    <= span_next;
      area_hi_reg <= area_hi_next;
      area_lo_reg <= area_lo_next;
      range1_reg  <= range1_next;
      post_reg    <= post_next;
      pre_reg     <= pre_next;
      rdata_reg   <= rdata_next;
      err_reg     <= err_next;
    end
  end

  // --------------------------------------------------------------------------
  // trigger sequence next values
  // --------------------------------------------------------------------------
  logic use_delay;
  assign use_delay = (post_reg != 32'h0) &
                     ~((cfg_reg.src == RTC_SRC_INTERNAL) & (cfg_reg.cond == RTC_COND_INSIDE));

  always_comb begin
    state_next    = state_reg;
    eff_lvl_next  = eff_lvl_reg;
    eff_half_next = eff_half_reg;
    buf_next      = buf_reg;
    pre_on_next   = pre_on_reg;
    dly_next      = dly_reg;
    trig_next     = 1'b0;
    case (state_reg)
      RTC_IDLE: begin
        if (rec_cmd) begin
          buf_next = cmd.buffered;
          if (level_flag)
            eff_lvl_next = (level_reg > area_hi_reg) ? 18'(area_hi_reg) : 18'(area_lo_reg);
          else
            eff_lvl_next = 18'(level_reg);
          // half span from its own setting, or range1 when span_flag is set
          // both arms 17 bits so the half span is never padded silently
          eff_half_next = span_flag ? {1'b0, range1_reg} : {2'b00, span_reg[15:1]};
          // pretrigger only when searched and buffered
          pre_on_next = cmd.buffered & (cfg_reg.src != RTC_SRC_MANUAL) & (pre_reg != 32'h0);
          dly_next    = 32'h0;
          if (cfg_reg.src == RTC_SRC_MANUAL) begin
            trig_next  = 1'b1;
            state_next = use_delay ? RTC_DELAY : RTC_RECORD;
          end else begin
            state_next = RTC_SEARCH;
          end
        end
      end
      RTC_SEARCH: begin
        if (found) begin
          trig_next  = 1'b1;
          state_next = use_delay ? RTC_DELAY : RTC_RECORD;
        end
      end
      RTC_DELAY: begin
        dly_next = dly_reg + 32'h1;
        if (dly_next >= post_reg) state_next = RTC_RECORD;
      end
      RTC_RECORD: begin
        if (rec_done) begin
          state_next  = RTC_IDLE;
          pre_on_next = 1'b0;
        end
      end
      default: state_next = RTC_IDLE;
    endcase
    if (cmd.stop | (rec_cmd & (state_reg != RTC_IDLE))) begin
      state_next  = RTC_IDLE;
      pre_on_next = 1'b0;
      trig_next   = 1'b0;
    end
  end

  // led: steady in search, divided blink in delay, off otherwise
  always_comb begin
    blink_next = 32'h0;
    led_next   = 1'b0;
    case (state_next)
      RTC_SEARCH: led_next = 1'b1;
      RTC_DELAY: begin
        if (state_reg != RTC_DELAY) begin
          led_next = 1'b0;
        end else if (blink_reg >= 32'(BLINK_HALF_CYC - 1)) begin
          led_next = ~led_reg;
        end else begin
          blink_next = blink_reg + 32'h1;
          led_next   = led_reg;
        end
      end
      default: led_next = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= RTC_IDLE;
      eff_lvl_reg  <= 18'h0;
      eff_half_reg <= 17'h0;
      buf_reg      <= 1'b0;
      pre_on_reg   <= 1'b0;
      dly_reg      <= 32'h0;
      blink_reg    <= 32'h0;
      led_reg      <= 1'b0;
      trig_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      eff_lvl_reg  <= eff_lvl_next;
      eff_half_reg <= eff_half_next;
      buf_reg      <= buf_next;
      pre_on_reg   <= pre_on_next;
      dly_reg      <= dly_next;
      blink_reg    <= blink_next;
      led_reg      <= led_next;
      trig_reg     <= trig_next;
    end
  end

  assign trigger_pulse = trig_reg;
  assign recording     = (state_reg == RTC_RECORD);
  assign buffered_mode = buf_reg;
  assign pretrig_store = pre_on_reg;
  assign search_led    = led_reg;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  manual_trig_a : assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RTC_IDLE && rec_cmd && !cmd.stop && cfg_reg.src == RTC_SRC_MANUAL)
      |=> trigger_pulse && state_reg != RTC_SEARCH)
    else $error("manual command did not trigger");
  ext_search_a : assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RTC_IDLE && rec_cmd && !cmd.stop && cfg_reg.src == RTC_SRC_EXTERNAL)
      |=> state_reg == RTC_SEARCH && search_led)
    else $error("external command did not start search");
  ext_edge_a : assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RTC_SEARCH && cfg_reg.src == RTC_SRC_EXTERNAL && fall && !cmd.stop && !rec_cmd)
      |=> trigger_pulse)
    else $error("falling edge missed in search");
  edge_ignored_a : assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RTC_IDLE && !rec_cmd) |=> !trigger_pulse)
    else $error("trigger outside a search");
  pin_released_a : assert property (@(posedge pclk) disable iff (!presetn)
    !remote_event_pin_oe && remote_event_pullup_en)
    else $error("remote line driven");
  above_hit_a : assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RTC_SEARCH && cfg_reg.src == RTC_SRC_INTERNAL && !cmd.stop && !rec_cmd
     && cfg_reg.cond == RTC_COND_ABOVE && ch1_valid && samp_x >= eff_lvl_reg)
      |=> trigger_pulse ##1 !trigger_pulse)
    else $error("above level missed");
  below_hit_a : assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == RTC_SEARCH && cfg_reg.src == RTC_SRC_INTERNAL && !cmd.stop && !rec_cmd
     && cfg_reg.cond == RTC_COND_BELOW && ch1_valid && samp_x > eff_lvl_reg)
      |=> !trigger_pulse)
    else $error("below level fired above threshold");
  inside_nodelay_a : assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_reg.src == RTC_SRC_INTERNAL && cfg_reg.cond == RTC_COND_INSIDE && state_reg == RTC_SEARCH)
      |=> state_reg != RTC_DELAY)
    else $error("post delay used for inside window");
  record_gate_a : assert property (@(posedge pclk) disable iff (!presetn)
    $rose(recording) |-> $past(trig_next) || $past(state_reg) == RTC_DELAY)
    else $error("recording began without trigger or delay");
  stop_idle_a : assert property (@(posedge pclk) disable iff (!presetn)
    cmd.stop |=> state_reg == RTC_IDLE && !search_led && !recording)
    else $error("stop did not return to idle");
endmodule // rtc_trigger_ctrl

// [rtc_far_model.sv]
// far side: remote trigger party and channel 1 sample source
// assumes the controller offers the pull-up and never drives the line
`timescale 1ns/1ps
module rtc_far_model (
  input  wire logic          pclk,
  input  wire logic          pull_low,   // party shorts line to ground
  input  wire logic          oe,
  input  wire logic          out,
  input  wire logic          pullup_en,
  output logic               line,
  output logic signed [15:0] ch1_sample,
  output logic               ch1_valid
);
  assign line = oe ? out : (pull_low ? 1'b0 : pullup_en);
  initial begin
    ch1_sample = 16'sh0;
    ch1_valid = 1'b0;
  end
  // one qualified sample; afterwards the bus shows the inverse, not a held value
  task automatic send(input logic signed [15:0] v);
    @(posedge pclk);
    ch1_sample <= v;
    ch1_valid <= 1'b1;
    @(posedge pclk);
    ch1_sample <= ~v;
    ch1_valid <= 1'b0;
  endtask
endmodule // rtc_far_model

// [tb.sv]
// self-checking bench for rtc_trigger_ctrl
// assumes rtc_far_model as channel source and remote party
`timescale 1ns/1ps
module tb;
  import rtc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rec_done = 0;
  logic pull_low = 0, er, seen, pready, pslverr, remote_event_pin_in, remote_event_pin_out;
  logic remote_event_pin_oe, remote_event_pullup_en, trigger_pulse, recording, search_led;
  logic buffered_mode, pretrig_store, level_flag, span_flag, ch1_valid;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic signed [15:0] ch1_sample, lvl, hlf;
  logic [15:0] lf = 16'h002d;  // random source state
  int mismatches = 0, comparisons = 0, cyc = 0, n;
  always #12.5 pclk = ~pclk;
  rtc_trigger_ctrl #(.BLINK_HALF_CYC(4)) i_rtc_trigger_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch1_sample(ch1_sample),
    .ch1_valid(ch1_valid), .rec_done(rec_done), .remote_event_pin_in(remote_event_pin_in),
    .remote_event_pin_out(remote_event_pin_out), .remote_event_pin_oe(remote_event_pin_oe),
    .remote_event_pullup_en(remote_event_pullup_en), .trigger_pulse(trigger_pulse),
    .recording(recording), .buffered_mode(buffered_mode), .pretrig_store(pretrig_store),
    .search_led(search_led), .level_flag(level_flag), .span_flag(span_flag));
  rtc_far_model i_rtc_far_model (.pclk(pclk), .pull_low(pull_low),
    .oe(remote_event_pin_oe), .out(remote_event_pin_out), .pullup_en(remote_event_pullup_en),
    .line(remote_event_pin_in), .ch1_sample(ch1_sample), .ch1_valid(ch1_valid));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // boundary sample that meets (h) or just misses condition c
  function automatic logic signed [15:0] sv(input int c, input bit h);
    case (c)
      0: return h ? lvl : lvl - 16'sd1;
      1: return h ? lvl : lvl + 16'sd1;
      2: return h ? lvl + hlf : lvl + hlf - 16'sd1;
      default: return h ? lvl - hlf : lvl - hlf - 16'sd1;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; next call waits an edge, so signals are never assigned twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask
  // bounded wait for the trigger pulse, n = cycles waited
  task automatic wtrig(input int lim);
    n = 0;
    #1;
    while (trigger_pulse !== 1'b1 && n < lim) begin
      tk(1);
      n++;
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, run needs a few hundred cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done;
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h010, 0);
    chk("area", rd, 32'hb1e0_4e20);
    apb(1, 12'h008, 32'h7fff);
    apb(0, 12'h008, 0);
    chk("level", rd[15:0], 16'h4e20);
    apb(0, 12'h0fc, 0);
    chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    chk("line", {remote_event_pin_out, remote_event_pin_oe, remote_event_pullup_en,
                 remote_event_pin_in}, 4'b0011);
    apb(1, 12'h01c, 5);
    apb(1, 12'h004, 2);
    wtrig(4);
    chk("manual", n < 2, 1);
    chk("man pre", {pretrig_store, buffered_mode, recording}, 3'b011);
    @(posedge pclk);
    rec_done <= 1'b1;
    @(posedge pclk);
    rec_done <= 1'b0;
    tk(2);
    chk("done", recording, 0);
    apb(1, 12'h000, 1);
    @(posedge pclk);
    pull_low <= 1'b1;
    tk(6);
    @(posedge pclk);
    pull_low <= 1'b0;
    apb(1, 12'h004, 2);
    tk(1);
    chk("search", {search_led, pretrig_store}, 2'b11);
    wtrig(8);
    chk("old edge", n, 8);
    @(posedge pclk);
    pull_low <= 1'b1;
    wtrig(10);
    chk("ext", n < 10, 1);
    chk("found", {search_led, recording}, 2'b01);
    apb(1, 12'h004, 4);
    tk(1);
    chk("stop", {recording, pretrig_store}, 0);
    apb(1, 12'h004, 1);
    tk(1);
    chk("direct", {search_led, pretrig_store}, 2'b10);
    apb(1, 12'h004, 1);
    tk(1);
    chk("abort", search_led, 0);
    apb(1, 12'h01c, 0);
    apb(1, 12'h018, 12);
    for (int c = 0; c < 4; c++) begin
      lf = lfsr(lf);
      lvl = $signed({4'h0, lf[11:0]}) - 16'sd2048;
      hlf = {8'h0, lf[15:8]} + 16'sd1;
      apb(1, 12'h008, {{16{lvl[15]}}, lvl});
      apb(1, 12'h00c, {15'h0, hlf, 1'b0});
      apb(1, 12'h000, 32'(c * 4 + 2));
      apb(1, 12'h004, 1);
      i_rtc_far_model.send(sv(c, 0));
      wtrig(4);
      chk("miss", n, 4);
      i_rtc_far_model.send(sv(c, 1));
      wtrig(4);
      chk("hit", n < 4, 1);
      tk(2);
      chk("post", recording, c == 3);
      apb(1, 12'h004, 4);
    end
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 1);
    wtrig(4);
    seen = 0;
    n = 0;
    while (recording !== 1'b1 && n < 30) begin
      tk(1);
      n++;
      seen = seen | (search_led === 1'b1);
    end
    chk("delay", n > 10 && n < 14, 1);
    chk("blink", {seen, search_led}, 2'b10);
    // recording still open: end it so the next record command starts a search
    apb(1, 12'h004, 4);
    apb(1, 12'h010, 32'hfc18_03e8);
    apb(1, 12'h008, 2000);
    apb(1, 12'h014, 100);
    apb(1, 12'h00c, 500);
    apb(1, 12'h018, 0);
    tk(1);
    chk("flags", {level_flag, span_flag}, 2'b11);
    apb(1, 12'h000, 2);
    apb(1, 12'h004, 1);
    i_rtc_far_model.send(16'sd1000);
    wtrig(4);
    chk("clamp", n < 4, 1);
    apb(1, 12'h004, 4);
    apb(1, 12'h000, 32'h0a);
    apb(1, 12'h004, 1);
    i_rtc_far_model.send(16'sd1100);
    wtrig(4);
    chk("span", n < 4, 1);
    test_done;
  end
endmodule // tb
